// [include/gpf_pkg.sv]
package gpf_pkg;

  localparam int NPORT = 5;
  localparam int PW = 8;
  localparam int NPIN = NPORT * PW;
  localparam int AW = 16;
  localparam int DW = 32;
  localparam int CODE_W = 4;

  // Address split: port number above, register offset below
  localparam int PSEL_LSB = 12;
  localparam int PSEL_W = 4;
  localparam int OFF_W = 12;
  localparam int MASK_LSB = 2;
  localparam int DATA_SEL_LSB = 10;
  localparam logic [1:0] DATA_SEL = 2'h0;

  localparam logic [11:0] OFF_DIR = 12'h400;
  localparam logic [11:0] OFF_SENSE = 12'h404;
  localparam logic [11:0] OFF_BOTH = 12'h408;
  localparam logic [11:0] OFF_EVENT = 12'h40C;
  localparam logic [11:0] OFF_IMASK = 12'h410;
  localparam logic [11:0] OFF_RIS = 12'h414;
  localparam logic [11:0] OFF_MIS = 12'h418;
  localparam logic [11:0] OFF_AFSEL = 12'h420;
  localparam logic [11:0] OFF_DR2 = 12'h500;
  localparam logic [11:0] OFF_DR4 = 12'h504;
  localparam logic [11:0] OFF_DR8 = 12'h508;
  localparam logic [11:0] OFF_ODR = 12'h50C;
  localparam logic [11:0] OFF_PUR = 12'h510;
  localparam logic [11:0] OFF_PDR = 12'h514;
  localparam logic [11:0] OFF_SLR = 12'h518;
  localparam logic [11:0] OFF_DEN = 12'h51C;
  localparam logic [11:0] OFF_ANALOG_SELECT_BIT = 12'h528;
  localparam logic [11:0] OFF_PCTL = 12'h52C;
  localparam logic [11:0] OFF_ADCEN = 12'h530;

  // Ports packed as {E, D, C, B, A}
  localparam logic [4:0][7:0] PIN_PRESENT = {8'h03, 8'h3F, 8'hFF, 8'hFF, 8'h3F};
  localparam logic [4:0][7:0] AFSEL_RST = {8'h00, 8'h00, 8'h0F, 8'h00, 8'h3F};
  localparam logic [4:0][7:0] DEN_RST = {8'h00, 8'h00, 8'h0F, 8'h00, 8'h3F};
  localparam logic [4:0][7:0] PUR_RST = {8'h00, 8'h00, 8'h0F, 8'h00, 8'h00};
  localparam logic [4:0][31:0] PCTL_RST = {32'h0000_0000, 32'h0000_0000,
    32'h0000_3333, 32'h0000_0000, 32'h0011_1111};
  // Mux code each pin's digital alternate function answers to
  localparam logic [4:0][31:0] FUNC_CODE = {32'h0000_0011, 32'h0011_1111,
    32'h1111_3333, 32'h1111_1111, 32'h0011_1111};

  typedef struct packed {
    logic [4:0][7:0] data;
    logic [4:0][7:0] dir;
    logic [4:0][7:0] sense;
    logic [4:0][7:0] both;
    logic [4:0][7:0] evt;
    logic [4:0][7:0] imask;
    logic [4:0][7:0] ris;
    logic [4:0][7:0] afsel;
    logic [4:0][7:0] dr2;
    logic [4:0][7:0] dr4;
    logic [4:0][7:0] dr8;
    logic [4:0][7:0] odr;
    logic [4:0][7:0] pur;
    logic [4:0][7:0] pdr;
    logic [4:0][7:0] slr;
    logic [4:0][7:0] digital_enable_bit;
    logic [4:0][7:0] analog_select_bit;
    logic [4:0][7:0] adcen;
    logic [4:0][7:0] prev;
    logic [4:0][31:0] pctl;
    logic [31:0] rdata;
    logic adc_trig;
  } gpf_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } gpf_sync_bit_t;

endpackage : gpf_pkg

// [design/gpf_sync.sv]
`timescale 1ns/1ps
module gpf_sync (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [39:0] async_i,
  output logic [39:0] sync_o
);
  gpf_pkg::gpf_sync_bit_t [39:0] q;
  gpf_pkg::gpf_sync_bit_t [39:0] next_q;

  always_comb begin
    for (int i = 0; i < gpf_pkg::NPIN; i++) begin
      next_q[i].s1 = async_i[i];
      next_q[i].s2 = q[i].s1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  always_comb begin
    for (int i = 0; i < gpf_pkg::NPIN; i++) begin
      sync_o[i] = q[i].s2;
    end
  end
endmodule : gpf_sync

// [design/gpf_gpio.sv]
`timescale 1ns/1ps
// How it works
// - Five identical port blocks of eight bits give thirty usable pins.
// - A written output level reaches the pin the next cycle, back to back.
// - Per-pin maskable interrupt on rising, falling, both edges, high or low level.
// - Data reads and writes are masked by address bits, not by data.
// - An enabled pin event pulses the converter start trigger.
// - Pads have pull-up, pull-down, 2/4/8 mA drive, slew at 8 mA, open drain, digital enable.
// - Isolated analog input only when digital enable clear and analog select set.
// - Comparator pins go analog by clearing digital enable alone.
// - Alternate function drives only with select, digital enable and matching mux code.
// - After reset other pins are tri-stated GPIO with all settings zero except 2 mA drive, which is set.
// - Port A bits 5:0 reset to alternate function, digital on, mux code 1.
// - Port C bits 3:0 reset to debug function with pull-up and mux code 3.
// - The single reset input returns every pin to its default configuration.
// - Direction 0 captures the pin into data; 1 drives data onto the pin.
// - Data write changes only bits whose address bit 9:2 is one.
module gpf_gpio (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic adc_trig_o,
  input wire logic [39:0] pin_i,
  output logic [39:0] pin_o,
  output logic [39:0] pin_oe_n_o,
  input wire logic [39:0] alt_out_i,
  input wire logic [39:0] alt_oe_i,
  output logic [39:0] alt_in_o,
  output logic [39:0] ana_iso_en_o,
  output logic [39:0] ana_direct_en_o,
  output logic [39:0] pad_pu_o,
  output logic [39:0] pad_pd_o,
  output logic [39:0] pad_drv2_o,
  output logic [39:0] pad_drv4_o,
  output logic [39:0] pad_drv8_o,
  output logic [39:0] pad_slew_o,
  output logic [39:0] pad_od_o
);
  localparam gpf_pkg::gpf_state_t RST_STATE = '{
    afsel: gpf_pkg::AFSEL_RST,
    digital_enable_bit: gpf_pkg::DEN_RST,
    pur: gpf_pkg::PUR_RST,
    pctl: gpf_pkg::PCTL_RST,
    dr2: gpf_pkg::PIN_PRESENT,
    default: '0
  };

  gpf_pkg::gpf_state_t q;
  gpf_pkg::gpf_state_t next_q;
  logic [39:0] sync_pin;
  logic [4:0][7:0] din;
  logic [4:0][7:0] ev;
  logic [4:0][7:0] alt_ok;
  logic [3:0] psel;
  logic [11:0] off;
  logic [7:0] amask;
  logic data_hit;

  function automatic logic port_hit(input logic [3:0] sel, input int p);
    port_hit = (sel == p[3:0]);
  endfunction : port_hit

  gpf_sync gpf_sync_i (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i(pin_i),
    .sync_o(sync_pin)
  );

  assign psel = addr_i[gpf_pkg::PSEL_LSB +: gpf_pkg::PSEL_W];
  assign off = addr_i[gpf_pkg::OFF_W-1:0];
  assign amask = addr_i[gpf_pkg::MASK_LSB +: gpf_pkg::PW];
  assign data_hit = (addr_i[gpf_pkg::DATA_SEL_LSB +: 2] == gpf_pkg::DATA_SEL);

  // Input qualification and interrupt event detection
  always_comb begin
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] lvl;
    logic [7:0] edg;
    rise = '0;
    fall = '0;
    lvl = '0;
    edg = '0;
    for (int p = 0; p < gpf_pkg::NPORT; p++) begin
      din[p] = sync_pin[p*gpf_pkg::PW +: gpf_pkg::PW] & q.digital_enable_bit[p] & gpf_pkg::PIN_PRESENT[p];
      rise = din[p] & ~q.prev[p];
      fall = ~din[p] & q.prev[p];
      lvl = (q.evt[p] & din[p]) | (~q.evt[p] & ~din[p]);
      edg = (q.both[p] & (rise | fall)) | (~q.both[p] & ((q.evt[p] & rise) | (~q.evt[p] & fall)));
      // Digitally disabled or absent pins make no events, in level modes too
      ev[p] = ((q.sense[p] & lvl) | (~q.sense[p] & edg))
        & q.digital_enable_bit[p] & gpf_pkg::PIN_PRESENT[p];
    end
  end

  always_comb begin
    logic [7:0] wd;
    logic [7:0] rclr;
    logic wr_p;
    logic rd_p;
    wd = '0;
    rclr = '0;
    wr_p = 1'b0;
    rd_p = 1'b0;
    next_q = q;
    next_q.rdata = '0;
    next_q.adc_trig = 1'b0;
    for (int p = 0; p < gpf_pkg::NPORT; p++) begin
      wr_p = wr_i && port_hit(psel, p);
      rd_p = rd_i && port_hit(psel, p);
      wd = wdata_i[gpf_pkg::PW-1:0] & gpf_pkg::PIN_PRESENT[p];
      next_q.data[p] = (q.data[p] & q.dir[p]) | (din[p] & ~q.dir[p]);
      next_q.prev[p] = din[p];
      rclr = (rd_p && off == gpf_pkg::OFF_RIS) ? 8'hFF : 8'h00;
      next_q.ris[p] = (q.ris[p] & ~rclr) | ev[p];
      if (|(ev[p] & q.adcen[p])) begin
        next_q.adc_trig = 1'b1;
      end
      if (wr_p && data_hit) begin
        next_q.data[p] = (next_q.data[p] & ~amask) | (wd & amask);
      end else if (wr_p) begin
        case (off)
          gpf_pkg::OFF_DIR: next_q.dir[p] = wd;
          gpf_pkg::OFF_SENSE: next_q.sense[p] = wd;
          gpf_pkg::OFF_BOTH: next_q.both[p] = wd;
          gpf_pkg::OFF_EVENT: next_q.evt[p] = wd;
          gpf_pkg::OFF_IMASK: next_q.imask[p] = wd;
          gpf_pkg::OFF_AFSEL: next_q.afsel[p] = wd;
          gpf_pkg::OFF_DR2: begin
            next_q.dr2[p] = q.dr2[p] | wd;
            next_q.dr4[p] = q.dr4[p] & ~wd;
            next_q.dr8[p] = q.dr8[p] & ~wd;
          end
          gpf_pkg::OFF_DR4: begin
            next_q.dr4[p] = q.dr4[p] | wd;
            next_q.dr2[p] = q.dr2[p] & ~wd;
            next_q.dr8[p] = q.dr8[p] & ~wd;
          end
          gpf_pkg::OFF_DR8: begin
            next_q.dr8[p] = q.dr8[p] | wd;
            next_q.dr2[p] = q.dr2[p] & ~wd;
            next_q.dr4[p] = q.dr4[p] & ~wd;
          end
          gpf_pkg::OFF_ODR: next_q.odr[p] = wd;
          gpf_pkg::OFF_PUR: begin
            next_q.pur[p] = wd;
            next_q.pdr[p] = q.pdr[p] & ~wd;
          end
          gpf_pkg::OFF_PDR: begin
            next_q.pdr[p] = wd;
            next_q.pur[p] = q.pur[p] & ~wd;
          end
          gpf_pkg::OFF_SLR: next_q.slr[p] = wd;
          gpf_pkg::OFF_DEN: next_q.digital_enable_bit[p] = wd;
          gpf_pkg::OFF_ANALOG_SELECT_BIT: next_q.analog_select_bit[p] = wd;
          gpf_pkg::OFF_PCTL: next_q.pctl[p] = wdata_i;
          gpf_pkg::OFF_ADCEN: next_q.adcen[p] = wd;
          default: next_q.pctl[p] = next_q.pctl[p];
        endcase
      end
      if (rd_p && data_hit) begin
        next_q.rdata = {24'h0, (q.data[p] & amask)};
      end else if (rd_p) begin
        case (off)
          gpf_pkg::OFF_DIR: next_q.rdata = {24'h0, q.dir[p]};
          gpf_pkg::OFF_SENSE: next_q.rdata = {24'h0, q.sense[p]};
          gpf_pkg::OFF_BOTH: next_q.rdata = {24'h0, q.both[p]};
          gpf_pkg::OFF_EVENT: next_q.rdata = {24'h0, q.evt[p]};
          gpf_pkg::OFF_IMASK: next_q.rdata = {24'h0, q.imask[p]};
          gpf_pkg::OFF_RIS: next_q.rdata = {24'h0, q.ris[p]};
          gpf_pkg::OFF_MIS: next_q.rdata = {24'h0, q.ris[p] & q.imask[p]};
          gpf_pkg::OFF_AFSEL: next_q.rdata = {24'h0, q.afsel[p]};
          gpf_pkg::OFF_DR2: next_q.rdata = {24'h0, q.dr2[p]};
          gpf_pkg::OFF_DR4: next_q.rdata = {24'h0, q.dr4[p]};
          gpf_pkg::OFF_DR8: next_q.rdata = {24'h0, q.dr8[p]};
          gpf_pkg::OFF_ODR: next_q.rdata = {24'h0, q.odr[p]};
          gpf_pkg::OFF_PUR: next_q.rdata = {24'h0, q.pur[p]};
          gpf_pkg::OFF_PDR: next_q.rdata = {24'h0, q.pdr[p]};
          gpf_pkg::OFF_SLR: next_q.rdata = {24'h0, q.slr[p]};
          gpf_pkg::OFF_DEN: next_q.rdata = {24'h0, q.digital_enable_bit[p]};
          gpf_pkg::OFF_ANALOG_SELECT_BIT: next_q.rdata = {24'h0, q.analog_select_bit[p]};
          gpf_pkg::OFF_PCTL: next_q.rdata = q.pctl[p];
          gpf_pkg::OFF_ADCEN: next_q.rdata = {24'h0, q.adcen[p]};
          default: next_q.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= RST_STATE;
    end else begin
      q <= next_q;
    end
  end

  // Pad and pin steering
  always_comb begin
    logic val;
    logic en;
    int i;
    val = 1'b0;
    en = 1'b0;
    i = 0;
    for (int p = 0; p < gpf_pkg::NPORT; p++) begin
      for (int b = 0; b < gpf_pkg::PW; b++) begin
        i = p * gpf_pkg::PW + b;
        // Each pin compares its own code field
        alt_ok[p][b] = q.afsel[p][b] && q.digital_enable_bit[p][b] &&
          (q.pctl[p][b*gpf_pkg::CODE_W +: gpf_pkg::CODE_W] ==
           gpf_pkg::FUNC_CODE[p][b*gpf_pkg::CODE_W +: gpf_pkg::CODE_W]);
        if (alt_ok[p][b]) begin
          val = alt_out_i[i];
          en = alt_oe_i[i];
        end else begin
          val = q.data[p][b];
          en = !q.afsel[p][b] && q.dir[p][b] && q.digital_enable_bit[p][b];
        end
        // Open drain only ever pulls low
        pin_o[i] = val && !q.odr[p][b];
        pin_oe_n_o[i] = !(en && gpf_pkg::PIN_PRESENT[p][b] && (!q.odr[p][b] || !val));
        alt_in_o[i] = din[p][b];
        ana_iso_en_o[i] = !q.digital_enable_bit[p][b] && q.analog_select_bit[p][b] && gpf_pkg::PIN_PRESENT[p][b];
        ana_direct_en_o[i] = !q.digital_enable_bit[p][b] && gpf_pkg::PIN_PRESENT[p][b];
        pad_pu_o[i] = q.pur[p][b];
        pad_pd_o[i] = q.pdr[p][b];
        pad_drv2_o[i] = q.dr2[p][b];
        pad_drv4_o[i] = q.dr4[p][b];
        pad_drv8_o[i] = q.dr8[p][b];
        pad_slew_o[i] = q.slr[p][b] && q.dr8[p][b];
        pad_od_o[i] = q.odr[p][b];
      end
    end
  end

  assign rdata_o = q.rdata;
  assign adc_trig_o = q.adc_trig;
  assign irq_o = |(q.ris & q.imask);

  a_data_mask_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_i && port_hit(psel, 1) && data_hit && !addr_i[gpf_pkg::MASK_LSB] && q.dir[1][0]
    |=> q.data[1][0] == $past(q.data[1][0]))
    else $error("masked data bit changed");

  a_read_mask_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
    rd_i && data_hit && amask == 8'h00 |=> rdata_o == 32'h0)
    else $error("masked data read not zero");

  a_output_follows: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_i && port_hit(psel, 1) && data_hit && addr_i[gpf_pkg::MASK_LSB] && q.dir[1][0]
    && q.digital_enable_bit[1][0] && !q.afsel[1][0] && !q.odr[1][0]
    |=> pin_o[8] == $past(wdata_i[0]) && !pin_oe_n_o[8])
    else $error("written output level not on pin");

  a_event_sticky_irq: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ev[1][6] && q.imask[1][6] && !(wr_i && off == gpf_pkg::OFF_IMASK)
    |=> q.ris[1][6] && irq_o)
    else $error("pin event did not raise interrupt");

  a_adc_trigger: assert property (@(posedge core_clk_i) disable iff (srst_i)
    |(ev[1] & q.adcen[1]) |=> adc_trig_o)
    else $error("converter trigger missing");

  a_gpio_owns_pin: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !q.afsel[1][0] && !q.odr[1][0]
    |-> pin_o[8] == q.data[1][0] && pin_oe_n_o[8] == !(q.dir[1][0] && q.digital_enable_bit[1][0]))
    else $error("GPIO does not own pin");

  a_alt_route: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !q.odr[3][0] && !alt_ok[3][0] && q.afsel[3][0] |-> pin_oe_n_o[24])
    else $error("alternate function drove without full enable");

  a_analog_iso: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ana_iso_en_o[12] |-> !alt_in_o[12] && pin_oe_n_o[12] && !q.digital_enable_bit[1][4] && q.analog_select_bit[1][4])
    else $error("isolated analog pin still digital");

  a_analog_direct: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ana_direct_en_o[12] |-> !alt_in_o[12] && pin_oe_n_o[12])
    else $error("comparator pin still digital");

  a_drive_select: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_i && port_hit(psel, 1) && off == gpf_pkg::OFF_DR8 && wdata_i[0]
    |=> pad_drv8_o[8] && !pad_drv2_o[8] && !pad_drv4_o[8])
    else $error("drive strength not exclusive");

  a_reset_defaults: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(srst_i) |-> q.afsel[0] == 8'h3F && q.pctl[0] == 32'h0011_1111
    && q.pur[2] == 8'h0F && q.pctl[2] == 32'h0000_3333 && q.digital_enable_bit[2] == 8'h0F)
    else $error("exception pins not at default");

  a_reset_tristate: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(srst_i) |-> &pin_oe_n_o[39:20] && &pin_oe_n_o[15:8] && q.digital_enable_bit[1] == 8'h00
    && q.pctl[3] == 32'h0)
    else $error("ordinary pins not tri-stated GPIO");

  a_adc_source: assert property (@(posedge core_clk_i) disable iff (srst_i)
    adc_trig_o |-> $past(|(ev & q.adcen)))
    else $error("converter trigger without enabled event");

  a_rdata_idle: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");

  a_ris_read_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
    rd_i && port_hit(psel, 1) && off == gpf_pkg::OFF_RIS && !ev[1][6]
    |=> !q.ris[1][6])
    else $error("status bit not cleared by read");

  a_pull_select: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_i && port_hit(psel, 1) && off == gpf_pkg::OFF_PDR && wdata_i[2]
    |=> pad_pd_o[10] && !pad_pu_o[10])
    else $error("pull-down select not exclusive");

  a_no_event_off: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !q.digital_enable_bit[1][4] |-> (ev[1] & ~q.digital_enable_bit[1]) == 8'h00 && !alt_in_o[12])
    else $error("digitally disabled pin made an event");

  a_input_capture: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !q.dir[1][7] && !(wr_i && data_hit && port_hit(psel, 1))
    |=> q.data[1][7] == $past(din[1][7]))
    else $error("input pin not captured into data");

  a_absent_pins: assert property (@(posedge core_clk_i) disable iff (srst_i)
    &pin_oe_n_o[7:6] && &pin_oe_n_o[31:30] && &pin_oe_n_o[39:34])
    else $error("absent pin driven");

  a_debug_alt: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(srst_i) |-> alt_ok[2][3:0] == 4'hF && alt_ok[0][5:0] == 6'h3F)
    else $error("reset pins not on their alternate function");

  a_reset_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(srst_i) |-> !irq_o && !adc_trig_o && rdata_o == 32'h0)
    else $error("outputs not quiet after reset");

  a_alt_drive: assert property (@(posedge core_clk_i) disable iff (srst_i)
    alt_ok[3][0] && !q.odr[3][0]
    |-> pin_o[24] == alt_out_i[24] && pin_oe_n_o[24] == !alt_oe_i[24])
    else $error("alternate function not on its pin");
endmodule : gpf_gpio

// [dv/gpf_pad_model.sv]
`timescale 1ns/1ps
module gpf_pad_model (
  input wire logic core_clk_i,
  input wire logic [39:0] pin_o_i,
  input wire logic [39:0] pin_oe_n_i,
  input wire logic [39:0] pad_pu_i,
  input wire logic [39:0] pad_pd_i,
  input wire logic [39:0] ext_en_i,
  input wire logic [39:0] ext_lvl_i,
  input wire logic [39:0] per_oe_i,
  input wire logic [39:0] per_val_i,
  output logic [39:0] pin_i_o,
  output logic [39:0] alt_out_o,
  output logic [39:0] alt_oe_o
);
  // An undriven, unpulled pin wanders every cycle
  logic [39:0] drift = 40'h55_5555_5555;
  always @(posedge core_clk_i) begin
    drift <= ~drift;
  end
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (!pin_oe_n_i[i]) pin_i_o[i] = pin_o_i[i];
      else if (ext_en_i[i]) pin_i_o[i] = ext_lvl_i[i];
      else if (pad_pu_i[i]) pin_i_o[i] = 1'b1;
      else if (pad_pd_i[i]) pin_i_o[i] = 1'b0;
      else pin_i_o[i] = drift[i];
    end
  end
  assign alt_out_o = per_val_i;
  assign alt_oe_o = per_oe_i;
endmodule : gpf_pad_model

// [dv/test_gpio_pin_function_config.sv]
`timescale 1ns/1ps
module test_gpio_pin_function_config;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq, adc;
  logic [39:0] pin_in, pin_out, oe_n, alt_out, alt_oe, alt_in, iso, dir_en;
  logic [39:0] pu, pd, d2, d4, d8, slew, od;
  logic [39:0] ext_en = 40'h00_0000_FF00;
  logic [39:0] ext_lvl = 40'h00_0000_0000;
  logic [39:0] per_oe = 40'h00_0100_0000;
  logic [39:0] per_val = 40'h00_0100_0000;
  int err_total = 0;
  int n_compared = 0;
  int adc_cnt = 0;
  int adc_ref;
  logic [31:0] d;
  // Entries are {port, offset, expected}
  localparam logic [47:0] DFLT [0:11] = '{
    {4'h0, gpf_pkg::OFF_AFSEL, 32'h0000_003F}, {4'h2, gpf_pkg::OFF_AFSEL, 32'h0000_000F},
    {4'h1, gpf_pkg::OFF_AFSEL, 32'h0000_0000}, {4'h0, gpf_pkg::OFF_DEN, 32'h0000_003F},
    {4'h2, gpf_pkg::OFF_DEN, 32'h0000_000F}, {4'h2, gpf_pkg::OFF_PUR, 32'h0000_000F},
    {4'h0, gpf_pkg::OFF_PDR, 32'h0000_0000}, {4'h0, gpf_pkg::OFF_PCTL, 32'h0011_1111},
    {4'h2, gpf_pkg::OFF_PCTL, 32'h0000_3333}, {4'h3, gpf_pkg::OFF_PCTL, 32'h0000_0000},
    {4'h1, gpf_pkg::OFF_DEN, 32'h0000_0000}, {4'h1, gpf_pkg::OFF_DIR, 32'h0000_0000}};
  // Interrupt modes as {sense, both, event, start level, end level}
  localparam logic [4:0] MODES [0:4] = '{5'b00101, 5'b00010, 5'b01001, 5'b10101, 5'b10010};

  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (adc === 1'b1) adc_cnt++;
  end

  gpf_gpio gpf_gpio_i (.core_clk_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .adc_trig_o(adc), .pin_i(pin_in),
    .pin_o(pin_out), .pin_oe_n_o(oe_n), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
    .alt_in_o(alt_in), .ana_iso_en_o(iso), .ana_direct_en_o(dir_en), .pad_pu_o(pu),
    .pad_pd_o(pd), .pad_drv2_o(d2), .pad_drv4_o(d4), .pad_drv8_o(d8), .pad_slew_o(slew),
    .pad_od_o(od));
  gpf_pad_model gpf_pad_model_i (.core_clk_i(clk), .pin_o_i(pin_out), .pin_oe_n_i(oe_n),
    .pad_pu_i(pu), .pad_pd_i(pd), .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .per_oe_i(per_oe),
    .per_val_i(per_val), .pin_i_o(pin_in), .alt_out_o(alt_out), .alt_oe_o(alt_oe));

  task automatic conclude();
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic wr_reg(input logic [3:0] port, input logic [11:0] off, input logic [31:0] v);
    @(posedge clk);
    addr <= {port, off};
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] port, input logic [11:0] off, output logic [31:0] v);
    @(posedge clk);
    addr <= {port, off};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  task automatic chk_word(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_rd(input logic [3:0] port, input logic [11:0] off, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(port, off, v);
    n_compared++;
    if (v !== exp) begin
      err_total++;
      $display("mismatch at %0t: read %h from %h expected %h", $time, v, {port, off}, exp);
    end
  endtask : chk_rd

  task automatic check_defaults();
    for (int i = 0; i < 12; i++) begin
      chk_rd(DFLT[i][47:44], DFLT[i][43:32], DFLT[i][31:0]);
    end
    chk_word(40'(pu[19:16]), 40'h0F);
  endtask : check_defaults

  initial begin
    #2_000_000;
    err_total++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    check_defaults();
    chk_rd(4'h5, gpf_pkg::OFF_DIR, 32'h0);
    chk_rd(4'h1, 12'h600, 32'h0);
    // Port B as outputs, masked data access
    wr_reg(4'h1, gpf_pkg::OFF_DEN, 32'hFF);
    wr_reg(4'h1, gpf_pkg::OFF_DIR, 32'hFF);
    wr_reg(4'h1, 12'h3FC, 32'h00);
    wr_reg(4'h1, 12'h098, 32'hEB);
    chk_word(40'(pin_out[15:8]), 40'h22);
    chk_word(40'(oe_n[15:8]), 40'h00);
    chk_rd(4'h1, 12'h3FC, 32'h22);
    chk_rd(4'h1, 12'h008, 32'h02);
    chk_rd(4'h1, 12'h000, 32'h00);
    wr_reg(4'h1, 12'h3FC, 32'hFF);
    chk_word(40'(pin_out[15:8]), 40'hFF);
    wr_reg(4'h1, 12'h3FC, 32'h00);
    chk_word(40'(pin_out[15:8]), 40'h00);
    wr_reg(4'h4, gpf_pkg::OFF_DEN, 32'hFF);
    wr_reg(4'h4, gpf_pkg::OFF_DIR, 32'hFF);
    chk_word(40'(oe_n[39:32]), 40'hFC);
    // Input capture on B7
    wr_reg(4'h1, gpf_pkg::OFF_DIR, 32'h3F);
    @(posedge clk);
    ext_lvl[15] <= 1'b1;
    repeat (4) @(posedge clk);
    chk_rd(4'h1, 12'h200, 32'h80);
    chk_word(40'(alt_in[15]), 40'h1);
    // Every detection mode on B6
    wr_reg(4'h1, gpf_pkg::OFF_IMASK, 32'h40);
    wr_reg(4'h1, gpf_pkg::OFF_ADCEN, 32'h40);
    for (int m = 0; m < 5; m++) begin
      wr_reg(4'h1, gpf_pkg::OFF_SENSE, {25'h0, MODES[m][4], 6'h0});
      wr_reg(4'h1, gpf_pkg::OFF_BOTH, {25'h0, MODES[m][3], 6'h0});
      wr_reg(4'h1, gpf_pkg::OFF_EVENT, {25'h0, MODES[m][2], 6'h0});
      @(posedge clk);
      ext_lvl[14] <= MODES[m][1];
      repeat (6) @(posedge clk);
      rd_reg(4'h1, gpf_pkg::OFF_RIS, d);
      rd_reg(4'h1, gpf_pkg::OFF_RIS, d);
      chk_word(40'(d[6]), 40'h0);
      adc_ref = adc_cnt;
      @(posedge clk);
      ext_lvl[14] <= MODES[m][0];
      repeat (6) @(posedge clk);
      chk_word(40'(irq), 40'h1);
      if (m == 0) chk_word(40'(adc_cnt - adc_ref), 40'h1);
      rd_reg(4'h1, gpf_pkg::OFF_RIS, d);
      chk_word(40'(d & 32'h40), 40'h40);
    end
    wr_reg(4'h1, gpf_pkg::OFF_IMASK, 32'h00);
    chk_word(40'(irq), 40'h0);
    chk_rd(4'h1, gpf_pkg::OFF_MIS, 32'h00);
    wr_reg(4'h1, gpf_pkg::OFF_IMASK, 32'h40);
    chk_word(40'(irq), 40'h1);
    // Analog routes on B4
    wr_reg(4'h1, gpf_pkg::OFF_DEN, 32'hEF);
    chk_word(40'({dir_en[12], iso[12]}), 40'h2);
    wr_reg(4'h1, gpf_pkg::OFF_ANALOG_SELECT_BIT, 32'h10);
    chk_word(40'(iso[12]), 40'h1);
    wr_reg(4'h1, gpf_pkg::OFF_DEN, 32'hFF);
    chk_word(40'({dir_en[12], iso[12]}), 40'h0);
    // Alternate function on D0, peripheral drives high
    wr_reg(4'h3, gpf_pkg::OFF_DEN, 32'h01);
    wr_reg(4'h3, gpf_pkg::OFF_PCTL, 32'h1);
    wr_reg(4'h3, gpf_pkg::OFF_AFSEL, 32'h01);
    chk_word(40'({oe_n[24], pin_out[24]}), 40'h1);
    wr_reg(4'h3, gpf_pkg::OFF_PCTL, 32'h2);
    chk_word(40'(oe_n[24]), 40'h1);
    wr_reg(4'h3, gpf_pkg::OFF_PCTL, 32'h1);
    wr_reg(4'h3, gpf_pkg::OFF_AFSEL, 32'h00);
    wr_reg(4'h3, gpf_pkg::OFF_DIR, 32'h01);
    wr_reg(4'h3, 12'h3FC, 32'h00);
    chk_word(40'({oe_n[24], pin_out[24]}), 40'h0);
    // Pad controls
    wr_reg(4'h1, gpf_pkg::OFF_DR8, 32'h01);
    chk_word(40'({d2[8], d4[8], d8[8]}), 40'h1);
    wr_reg(4'h1, gpf_pkg::OFF_SLR, 32'h01);
    chk_word(40'(slew[8]), 40'h1);
    wr_reg(4'h1, gpf_pkg::OFF_ODR, 32'h02);
    chk_word(40'(od[9]), 40'h1);
    wr_reg(4'h1, gpf_pkg::OFF_PDR, 32'h04);
    chk_word(40'({pu[10], pd[10]}), 40'h1);
    wr_reg(4'h1, gpf_pkg::OFF_PUR, 32'h04);
    chk_word(40'({pu[10], pd[10]}), 40'h2);
    // Second reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    check_defaults();
    chk_rd(4'h3, gpf_pkg::OFF_AFSEL, 32'h0);
    chk_rd(4'h1, gpf_pkg::OFF_PUR, 32'h0);
    conclude();
  end
endmodule : test_gpio_pin_function_config
